//--- core/dlfp_dev.sv
// device end: unlock and programming-port registers behind the debug link
// assumes the host makes the link clock and the flash side runs on it;
// i_halted comes from the system clock domain and is synchronised here
//
// Design decision made here: the debug-link frame interface to the registers.
`timescale 1ns/100ps

module dlfp_dev (
  // link side, clocked by the link clock
  dlfp_link_if.device lnk,
  // system reset and halt state
  input wire logic i_rst_n,
  input wire logic i_halted,
  // flash side
  input wire logic i_flash_rd_valid,
  input wire logic [7:0] i_flash_rd_byte,
  input wire logic i_flash_done,
  output logic o_prog_en,
  output logic o_cmd_start,
  output logic [7:0] o_cmd,
  output logic o_byte_wr,
  output logic [7:0] o_byte,
  output logic o_cmd_rejected
);
  typedef struct packed {
    dlfp_pkg::dlfp_dev_st_t st;
    logic [3:0] cnt;
    logic [1:0] ins;
    logic [7:0] sh;
    logic [7:0] sel;
    logic [7:0] unlock;
    logic [7:0] port;
    logic key1;
    logic prog_en;
    logic cmd_act;
    logic [7:0] cmd;
    logic cmd_start;
    logic byte_wr;
    logic rejected;
    logic dout;
    logic doe;
  } dlfp_dev_state_t;

  dlfp_dev_state_t s_q;
  dlfp_dev_state_t s_d;
  logic halted_s;
  logic [7:0] wr_byte;
  logic [7:0] rd_byte;

  // halt comes from the system domain
  dlfp_sync u_halt_sync (
    .i_clk(lnk.clk),
    .i_rst_n(i_rst_n),
    .i_d(i_halted),
    .o_q(halted_s)
  );

  // byte complete on the last data edge, lsb first
  assign wr_byte = {lnk.dat, s_q.sh[7:1]};

  always_comb begin
    unique case (s_q.sel)
      dlfp_pkg::ADDR_UNLOCK: rd_byte = s_q.unlock;
      dlfp_pkg::ADDR_PORT: rd_byte = s_q.port;
      default: rd_byte = dlfp_pkg::READ_NONE;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.cmd_start = 1'b0;
    s_d.byte_wr = 1'b0;
    s_d.rejected = 1'b0;
    if (i_flash_rd_valid) begin
      s_d.port = i_flash_rd_byte;
    end
    if (i_flash_done) begin
      s_d.cmd_act = 1'b0;
    end
    if (!halted_s) begin
      // running part: link pins belong to the user, device stays off them
      s_d.st = dlfp_pkg::DEV_IDLE;
      s_d.doe = 1'b0;
    end else begin
      unique case (s_q.st)
        dlfp_pkg::DEV_IDLE: begin
          // a start bit opens the frame; data pin is steady otherwise
          if (lnk.dat) begin
            s_d.st = dlfp_pkg::DEV_INS;
            s_d.cnt = '0;
          end
        end
        dlfp_pkg::DEV_INS: begin
          s_d.ins = {lnk.dat, s_q.ins[1]};
          s_d.cnt = s_q.cnt + 4'h1;
          if (s_q.cnt != '0) begin
            s_d.cnt = '0;
            if (dlfp_pkg::is_read_ins({lnk.dat, s_q.ins[1]})) begin
              s_d.st = dlfp_pkg::DEV_TURN;
            end else begin
              s_d.st = dlfp_pkg::DEV_XFER;
            end
          end
        end
        dlfp_pkg::DEV_TURN: begin
          // host released the line during this slot; drive bit 0
          s_d.st = dlfp_pkg::DEV_XFER;
          s_d.doe = 1'b1;
          if (s_q.ins == dlfp_pkg::INS_ADDR_RD) begin
            s_d.dout = s_q.sel[0];
            s_d.sh = {1'b0, s_q.sel[7:1]};
          end else begin
            s_d.dout = rd_byte[0];
            s_d.sh = {1'b0, rd_byte[7:1]};
          end
        end
        dlfp_pkg::DEV_XFER: begin
          if (dlfp_pkg::is_read_ins(s_q.ins)) begin
            if (s_q.cnt == dlfp_pkg::LAST_BIT) begin
              s_d.doe = 1'b0;
              s_d.st = dlfp_pkg::DEV_IDLE;
            end else begin
              s_d.cnt = s_q.cnt + 4'h1;
              s_d.dout = s_q.sh[0];
              s_d.sh = {1'b0, s_q.sh[7:1]};
            end
          end else if (s_q.cnt != dlfp_pkg::LAST_BIT) begin
            s_d.sh = wr_byte;
            s_d.cnt = s_q.cnt + 4'h1;
          end else begin
            s_d.st = dlfp_pkg::DEV_IDLE;
            if (s_q.ins == dlfp_pkg::INS_ADDR_WR) begin
              s_d.sel = wr_byte;
            end else if (s_q.sel == dlfp_pkg::ADDR_UNLOCK) begin
              s_d.unlock = wr_byte;
              if (!s_q.prog_en) begin
                if (s_q.key1 && wr_byte == dlfp_pkg::KEY_SECOND) begin
                  s_d.prog_en = 1'b1;
                  s_d.key1 = 1'b0;
                end else begin
                  // a repeated first key counts as a fresh start
                  s_d.key1 = (wr_byte == dlfp_pkg::KEY_FIRST);
                end
              end
            end else if (s_q.sel == dlfp_pkg::ADDR_PORT) begin
              s_d.port = wr_byte;
              if (!s_q.prog_en) begin
                s_d.rejected = 1'b1;
              end else if (s_q.cmd_act && !i_flash_done) begin
                s_d.byte_wr = 1'b1;
              end else if (dlfp_pkg::is_flash_cmd(wr_byte)) begin
                s_d.cmd_start = 1'b1;
                s_d.cmd = wr_byte;
                s_d.cmd_act = 1'b1;
              end else begin
                s_d.rejected = 1'b1;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge lnk.clk) begin
    if (!i_rst_n) begin
      // only a system reset leaves programming mode
      s_q <= '0;
      s_q.st <= dlfp_pkg::DEV_IDLE;
      s_q.sel <= dlfp_pkg::SEL_RST;
      s_q.unlock <= dlfp_pkg::UNLOCK_RST;
      s_q.port <= dlfp_pkg::PORT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign lnk.dat_d = s_q.dout;
  assign lnk.dat_d_oe = s_q.doe;
  assign o_prog_en = s_q.prog_en;
  assign o_cmd_start = s_q.cmd_start;
  assign o_cmd = s_q.cmd;
  assign o_byte_wr = s_q.byte_wr;
  assign o_byte = s_q.port;
  assign o_cmd_rejected = s_q.rejected;
endmodule

//--- pkg/dlfp_pkg.sv
// constants, encodings and types shared by both ends of the debug link
// assumes both ends and the link interface import nothing, naming dlfp_pkg::
package dlfp_pkg;
  // registers behind the link
  localparam logic [7:0] ADDR_UNLOCK = 8'h02;
  localparam logic [7:0] ADDR_PORT = 8'hB4;
  localparam logic [7:0] UNLOCK_RST = 8'h00;
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;
  localparam logic [7:0] KEY_FIRST = 8'h02;
  localparam logic [7:0] KEY_SECOND = 8'h01;
  // flash commands carried by the programming port
  localparam logic [7:0] CMD_BLOCK_READ = 8'h06;
  localparam logic [7:0] CMD_BLOCK_WRITE = 8'h07;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h08;
  localparam logic [7:0] CMD_DEVICE_ERASE = 8'h03;
  // frame: start bit 1, two instruction bits, a turnaround slot on reads, then eight data bits lsb first
  localparam logic [1:0] INS_DATA_RD = 2'h0;
  localparam logic [1:0] INS_DATA_WR = 2'h1;
  localparam logic [1:0] INS_ADDR_WR = 2'h2;
  localparam logic [1:0] INS_ADDR_RD = 2'h3;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] WR_SLOTS = 4'hB;
  localparam logic [3:0] RD_SLOTS = 4'hC;
  localparam logic [3:0] HDR_SLOTS = 4'h3;
  localparam logic [3:0] RX_FIRST = 4'h4;
  // host link clock divider
  localparam int SYS_CLK_NS = 5;
  localparam int LINK_HALF_NS = 25;
  localparam logic [3:0] LINK_HALF_CYC = 4'(LINK_HALF_NS / SYS_CLK_NS);
  // host register map on apb
  localparam logic [31:0] REG_CMD = 32'h0000_0000;
  localparam logic [31:0] REG_STATUS = 32'h0000_0004;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_GO_BIT = 2;
  localparam int CMD_RST_BIT = 3;
  localparam int CMD_DATA_LSB = 8;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_RX_LSB = 8;

  typedef enum logic [1:0] {DEV_IDLE, DEV_INS, DEV_TURN, DEV_XFER} dlfp_dev_st_t;
  typedef enum logic [1:0] {HST_IDLE, HST_LOW, HST_HIGH} dlfp_hst_st_t;

  function automatic logic is_flash_cmd(input logic [7:0] b);
    is_flash_cmd = (b == CMD_BLOCK_READ) || (b == CMD_BLOCK_WRITE) ||
                   (b == CMD_PAGE_ERASE) || (b == CMD_DEVICE_ERASE);
  endfunction

  function automatic logic is_read_ins(input logic [1:0] ins);
    is_read_ins = (ins == INS_DATA_RD) || (ins == INS_ADDR_RD);
  endfunction
endpackage

//--- pkg/dlfp_link_if.sv
// two-wire debug link: host-made clock and one shared data line
// assumes a pull-up keeps the data line high when nobody drives it
`timescale 1ns/100ps
interface dlfp_link_if;
  logic clk;
  logic dat_h;
  logic dat_h_oe;
  logic dat_d;
  logic dat_d_oe;
  logic dat;

  // device wins a clash so a late release cannot hide its bit
  assign dat = dat_d_oe ? dat_d : (dat_h_oe ? dat_h : 1'b1);

  modport host (output clk, output dat_h, output dat_h_oe, input dat);
  modport device (input clk, input dat, output dat_d, output dat_d_oe);
endinterface

//--- core/dlfp_sync.sv
// two flip-flop level synchroniser
// assumes i_d is a level from another clock domain
`timescale 1ns/100ps
module dlfp_sync (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // level in and out
  input wire logic i_d,
  output logic o_q
);
  logic [1:0] sync_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sync_q <= 2'h0;
    end else begin
      sync_q <= {sync_q[0], i_d};
    end
  end

  assign o_q = sync_q[1];
endmodule

//--- core/dlfp_host.sv
// host end: apb-programmed frame engine that drives the debug link
// assumes the target is halted while frames run and samples on rising clock
`timescale 1ns/100ps
module dlfp_host (
  // system clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // target reset request
  output logic o_target_rst,
  // link
  dlfp_link_if.host lnk
);
  typedef struct packed {
    dlfp_pkg::dlfp_hst_st_t st;
    logic [3:0] div;
    logic [3:0] idx;
    logic [3:0] last;
    logic rd;
    logic [10:0] tx;
    logic [7:0] rx;
    logic clk;
    logic dout;
    logic doe;
    logic tgt_rst;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dlfp_hst_state_t;

  dlfp_hst_state_t s_q;
  dlfp_hst_state_t s_d;
  logic dat_s;
  logic wr_cmd;
  logic [1:0] op;
  logic [7:0] byte_out;

  dlfp_sync u_dat_sync (
    .i_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_d(lnk.dat),
    .o_q(dat_s)
  );

  assign wr_cmd = i_psel && i_penable && s_q.pready && i_pwrite &&
                  (i_paddr == dlfp_pkg::REG_CMD);
  assign op = i_pwdata[dlfp_pkg::CMD_OP_LSB +: 2];
  assign byte_out = i_pwdata[dlfp_pkg::CMD_DATA_LSB +: 8];

  always_comb begin
    s_d = s_q;
    s_d.pready = 1'b0;
    // answer in the first access cycle
    if (i_psel && !i_penable) begin
      s_d.pready = 1'b1;
      s_d.pslverr = (i_paddr != dlfp_pkg::REG_CMD) &&
                    (i_paddr != dlfp_pkg::REG_STATUS);
      s_d.prdata = '0;
      if (i_paddr == dlfp_pkg::REG_STATUS) begin
        s_d.prdata[dlfp_pkg::ST_BUSY_BIT] = (s_q.st != dlfp_pkg::HST_IDLE);
        s_d.prdata[dlfp_pkg::ST_RX_LSB +: 8] = s_q.rx;
      end
    end
    if (wr_cmd) begin
      // software pulses this to return the part to normal operation
      s_d.tgt_rst = i_pwdata[dlfp_pkg::CMD_RST_BIT];
    end
    unique case (s_q.st)
      dlfp_pkg::HST_IDLE: begin
        s_d.clk = 1'b0;
        s_d.dout = 1'b0;
        s_d.doe = 1'b1;
        // software starts frames only while the target is halted
        if (wr_cmd && i_pwdata[dlfp_pkg::CMD_GO_BIT]) begin
          s_d.st = dlfp_pkg::HST_LOW;
          s_d.div = '0;
          s_d.idx = '0;
          s_d.rd = dlfp_pkg::is_read_ins(op);
          // unlock keys, addresses and flash commands all go as data bytes
          s_d.tx = {byte_out, op, 1'b1};
          s_d.last = dlfp_pkg::is_read_ins(op) ? dlfp_pkg::RD_SLOTS
                                               : dlfp_pkg::WR_SLOTS;
          s_d.dout = 1'b1;
        end
      end
      dlfp_pkg::HST_LOW: begin
        s_d.clk = 1'b0;
        s_d.div = s_q.div + 4'h1;
        if (s_q.div == 4'h0) begin
          // host lets go of the line for turnaround and read bits
          s_d.doe = !s_q.rd || (s_q.idx < dlfp_pkg::HDR_SLOTS);
          // read frames run past the sent bits; those slots stay low
          s_d.dout = (s_q.idx < dlfp_pkg::WR_SLOTS) ? s_q.tx[s_q.idx]
                                                   : 1'b0;
        end
        if (s_q.div == dlfp_pkg::LINK_HALF_CYC - 4'h1) begin
          s_d.div = '0;
          s_d.st = dlfp_pkg::HST_HIGH;
          s_d.clk = 1'b1;
          if (s_q.rd && s_q.idx >= dlfp_pkg::RX_FIRST) begin
            s_d.rx = {dat_s, s_q.rx[7:1]};
          end
        end
      end
      dlfp_pkg::HST_HIGH: begin
        s_d.div = s_q.div + 4'h1;
        if (s_q.div == dlfp_pkg::LINK_HALF_CYC - 4'h1) begin
          s_d.div = '0;
          s_d.clk = 1'b0;
          s_d.idx = s_q.idx + 4'h1;
          s_d.st = (s_q.idx == s_q.last - 4'h1) ? dlfp_pkg::HST_IDLE
                                                : dlfp_pkg::HST_LOW;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      s_q <= '0;
      s_q.st <= dlfp_pkg::HST_IDLE;
      s_q.doe <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // the link clock pin carries s_q.clk; nothing else may drive it
  assign lnk.clk = s_q.clk;
  assign lnk.dat_h = s_q.dout;
  assign lnk.dat_h_oe = s_q.doe;
  assign o_prdata = s_q.prdata;
  assign o_pready = s_q.pready;
  assign o_pslverr = s_q.pslverr;
  assign o_target_rst = s_q.tgt_rst;
endmodule

//--- tb/dlfp_monitor.sv
// link wire checker: clock shape, data timing and frame length
// assumes the host moves link signals only on i_sys_clk edges
`timescale 1ns/100ps
module dlfp_monitor (
  // system clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // link signals
  input wire logic clk,
  input wire logic dat_h,
  input wire logic dat_h_oe,
  input wire logic dat_d,
  input wire logic dat_d_oe,
  input wire logic dat
);
  logic [3:0] low_q;
  logic [3:0] rise_q;
  logic clk_q;

  // low for more than one slot half means the link is idle
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      low_q <= 4'h0;
      rise_q <= 4'h0;
      clk_q <= 1'b0;
    end else begin
      clk_q <= clk;
      low_q <= clk ? 4'h0 : ((low_q == 4'h7) ? low_q : low_q + 4'h1);
      if (low_q == 4'h6) begin
        rise_q <= 4'h0;
      end else if (clk && !clk_q) begin
        rise_q <= rise_q + 4'h1;
      end
    end
  end

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  property p_clk_high;
    $rose(clk) |-> clk [*5] ##1 !clk;
  endproperty
  a_clk_high: assert property (p_clk_high)
    else $error("link clock high phase wrong");
  property p_clk_low;
    $fell(clk) |-> !clk [*5];
  endproperty
  a_clk_low: assert property (p_clk_low)
    else $error("link clock low phase short");
  property p_host_chg;
    $changed(dat_h) |-> !clk;
  endproperty
  a_host_chg: assert property (p_host_chg)
    else $error("host data moved while clock high");
  property p_dev_chg;
    $changed(dat_d) || $changed(dat_d_oe) |-> $rose(clk);
  endproperty
  a_dev_chg: assert property (p_dev_chg)
    else $error("device data moved off a rising clock");
  property p_frame_len;
    low_q == 4'h6 && rise_q != 4'h0 |-> rise_q inside {4'hB, 4'hC};
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame slot count wrong");
  property p_start;
    $rose(clk) && rise_q == 4'h0 |-> dat;
  endproperty
  a_start: assert property (p_start)
    else $error("frame without start bit");
  // the start bit rises while the idle low phase still runs
  property p_idle;
    low_q == 4'h7 |-> dat_h_oe;
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle link not driven by host");
  property p_idle_lvl;
    low_q == 4'h7 && dat_h |-> ##[1:6] clk;
  endproperty
  a_idle_lvl: assert property (p_idle_lvl)
    else $error("idle data line high without a frame");
  property p_turn;
    $rose(dat_d_oe) |-> $rose(clk) && rise_q == 4'h3 && !dat_h_oe;
  endproperty
  a_turn: assert property (p_turn)
    else $error("device drove outside turnaround");

  c_write: cover property (low_q == 4'h6 && rise_q == 4'hB);
  c_read: cover property (low_q == 4'h6 && rise_q == 4'hC);
  c_drive: cover property ($rose(dat_d_oe));
endmodule

//--- tb/dlfp_tb.sv
// bench: host and device ends joined by the debug link, driven over apb
// assumes the host makes every link edge, so device reset and halt sync
// are carried by throwaway frames
`timescale 1ns/100ps
module dlfp_tb;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic halted = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trst = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd_w;
  logic pready, pslverr, perr, target_rst, prog_en;
  logic cmd_start, byte_wr, rejected, rd_valid = 1'b0, done = 1'b0;
  logic [7:0] cmd, obyte, v, rd_byte = 8'h00, last_cmd = 8'h00;
  logic [7:0] cmds [4] = '{dlfp_pkg::CMD_BLOCK_READ,
    dlfp_pkg::CMD_BLOCK_WRITE, dlfp_pkg::CMD_PAGE_ERASE,
    dlfp_pkg::CMD_DEVICE_ERASE};
  int miscompares = 0, check_count = 0, n_start = 0, n_rej = 0, n_bw = 0;

  always #2.5 i_sys_clk = ~i_sys_clk;

  dlfp_link_if lnk ();
  dlfp_host dlfp_host_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_target_rst(target_rst),
    .lnk(lnk.host));
  dlfp_dev dlfp_dev_i (.lnk(lnk.device), .i_rst_n(i_rst_n & ~target_rst),
    .i_halted(halted), .i_flash_rd_valid(rd_valid),
    .i_flash_rd_byte(rd_byte), .i_flash_done(done), .o_prog_en(prog_en),
    .o_cmd_start(cmd_start), .o_cmd(cmd), .o_byte_wr(byte_wr),
    .o_byte(obyte), .o_cmd_rejected(rejected));
  dlfp_monitor dlfp_monitor_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .clk(lnk.clk), .dat_h(lnk.dat_h), .dat_h_oe(lnk.dat_h_oe),
    .dat_d(lnk.dat_d), .dat_d_oe(lnk.dat_d_oe), .dat(lnk.dat));

  // flash-side pulses only move on link edges, which stop between frames
  always @(posedge lnk.clk) begin
    if (cmd_start === 1'b1) begin
      n_start++;
      last_cmd = cmd;
    end
    n_rej += (rejected === 1'b1);
    n_bw += (byte_wr === 1'b1);
    if (rd_valid) rd_valid <= 1'b0;
    if (done) done <= 1'b0;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge i_sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    // pready ends this wait; only the watchdog limits it
    do begin
      @(posedge i_sys_clk);
    end while (pready !== 1'b1);
    rd_w = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic frame(input logic [1:0] op, input logic [7:0] b);
    int n;
    n = 0;
    apb(1'b1, dlfp_pkg::REG_CMD, {16'h0000, b, 4'h0, trst, 1'b1, op});
    repeat (2) @(posedge i_sys_clk);
    do begin
      apb(1'b0, dlfp_pkg::REG_STATUS, 32'h0000_0000);
      n++;
    end while (rd_w[0] !== 1'b0 && n < 100);
    if (rd_w[0] !== 1'b0) begin
      miscompares++;
      close_out();
    end
  endtask

  task automatic lrd(input logic [7:0] a, output logic [7:0] r);
    frame(dlfp_pkg::INS_ADDR_WR, a);
    frame(dlfp_pkg::INS_DATA_RD, 8'h00);
    r = rd_w[15:8];
  endtask

  task automatic lwr(input logic [7:0] a, input logic [7:0] d);
    frame(dlfp_pkg::INS_ADDR_WR, a);
    frame(dlfp_pkg::INS_DATA_WR, d);
  endtask

  // zero data after the start keeps a half-synced device from framing
  task automatic boot();
    trst = 1'b1;
    frame(dlfp_pkg::INS_DATA_WR, 8'h00);
    trst = 1'b0;
    frame(dlfp_pkg::INS_DATA_WR, 8'h00);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #400000;
    miscompares++;
    close_out();
  end

  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    boot();
    apb(1'b0, 32'h0000_0008, 32'h0);
    chk(perr, 1'b1);
    lrd(8'h02, v);
    chk(v, 8'h00);
    lrd(8'hB4, v);
    chk(v, 8'h00);
    chk(prog_en, 1'b0);
    $display("reset test done");
    halted <= 1'b0;
    frame(dlfp_pkg::INS_DATA_WR, 8'h00);
    lrd(8'hB4, v);
    chk(v, 8'hFF);
    halted <= 1'b1;
    frame(dlfp_pkg::INS_DATA_WR, 8'h00);
    $display("halt test done");
    n_rej = 0;
    n_start = 0;
    lwr(8'hB4, 8'h06);
    lrd(8'h02, v);
    chk(n_rej, 1);
    chk(n_start, 0);
    lwr(8'h02, 8'h02);
    frame(dlfp_pkg::INS_DATA_WR, 8'h05);
    frame(dlfp_pkg::INS_DATA_WR, 8'h01);
    lrd(8'h02, v);
    chk(v, 8'h01);
    chk(prog_en, 1'b0);
    lwr(8'h02, 8'h02);
    frame(dlfp_pkg::INS_DATA_WR, 8'h02);
    frame(dlfp_pkg::INS_DATA_WR, 8'h01);
    chk(prog_en, 1'b1);
    $display("unlock test done");
    n_start = 0;
    n_bw = 0;
    for (int i = 0; i < 4; i++) begin
      lwr(8'hB4, cmds[i]);
      frame(dlfp_pkg::INS_DATA_WR, 8'h5A);
      done <= 1'b1;
      lrd(8'hB4, v);
      chk(last_cmd, cmds[i]);
      chk(n_start, i + 1);
      chk(n_bw, i + 1);
      chk(v, 8'h5A);
      chk(obyte, 8'h5A);
    end
    rd_byte <= 8'hC3;
    rd_valid <= 1'b1;
    lrd(8'hB4, v);
    chk(v, 8'hC3);
    n_rej = 0;
    lwr(8'hB4, 8'h55);
    lrd(8'hB4, v);
    chk(n_rej, 1);
    chk(n_start, 4);
    chk(v, 8'h55);
    $display("command test done");
    lwr(8'h02, 8'h00);
    chk(prog_en, 1'b1);
    n_rej = 0;
    boot();
    chk(prog_en, 1'b0);
    lwr(8'hB4, 8'h07);
    lrd(8'h02, v);
    chk(v, 8'h00);
    chk(n_rej, 1);
    $display("system reset test done");
    close_out();
  end
endmodule
